/* adcc_pkg.sv */
// Constants and carrier types for the converter control block.
// Assumes a classic Wishbone slave with byte registers in the low lane of each word.
package adcc_pkg;
  // ==========================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [7:0] SC1_OFS = 8'h00;
  localparam logic [7:0] SC2_OFS = 8'h04;
  localparam logic [7:0] RES_LO_OFS = 8'h08;
  localparam logic [7:0] RES_HI_OFS = 8'h0c;
  localparam logic [7:0] CMP_LO_OFS = 8'h10;
  localparam logic [7:0] CMP_HI_OFS = 8'h14;

  // ==========================================================
  // Field positions
  localparam int DONE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int RUN_BIT = 7;
  localparam int TRIG_BIT = 6;
  localparam int CMP_EN_BIT = 5;
  localparam int CMP_GT_BIT = 4;

  // ==========================================================
  // Channel codes and reset values
  localparam logic [4:0] CH_LAST_INPUT = 5'h1b;
  localparam logic [4:0] CH_RESERVED = 5'h1c;
  localparam logic [4:0] CH_REF_HIGH = 5'h1d;
  localparam logic [4:0] CH_REF_LOW = 5'h1e;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [7:0] SC1_RESET = 8'h1f;
  localparam logic [7:0] SC2_RESET = 8'h00;
  localparam logic [9:0] CMP_RESET = 10'h000;

  // ==========================================================
  // Types
  typedef enum logic {ADCC_IDLE, ADCC_CONVERT} adcc_state_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic [4:0] input_index;
    logic ref_high;
    logic ref_low;
    logic isolate;
    logic low_power;
  } adcc_conv_req_t;

  typedef struct packed {
    logic done;
    logic [9:0] result;
  } adcc_conv_ans_t;
endpackage

/* adcc_ctrl.sv */
// Conversion control and status for a successive-approximation converter.
// Assumes the analog core runs on ref_clk, takes a one-cycle start or abort
// and returns a one-cycle done with its result; the trigger pin is asynchronous.
`timescale 1ns/1ps

module adcc_ctrl (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hw_trigger_in,
  input wire adcc_pkg::adcc_conv_ans_t conv_ans,
  output adcc_pkg::adcc_conv_req_t conv_req,
  output logic irq
);

  // ==========================================================
  // Helpers
  // Address match on the word, low two bits ignored
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Compare condition; passes always when compare is off
  function automatic logic cmp_pass(input logic en, input logic gt, input logic [9:0] res,
                                    input logic [9:0] cv);
    if (!en) begin
      cmp_pass = 1'b1;
    end else if (gt) begin
      cmp_pass = (res >= cv);
    end else begin
      cmp_pass = (res < cv);
    end
  endfunction

  // ==========================================================
  // State
  adcc_pkg::adcc_state_t state, next_state;
  logic done_flag, next_done_flag;
  logic irq_en, next_irq_en;
  logic cont_en, next_cont_en;
  logic [4:0] channel_select, next_channel_select;
  logic trig_hw, next_trig_hw;
  logic cmp_en, next_cmp_en;
  logic cmp_gt, next_cmp_gt;
  logic [9:0] cmp_value, next_cmp_value;
  logic [9:0] result, next_result;
  logic trig_s1, trig_s2, trig_prev;
  logic [31:0] next_dat;
  logic next_ack;
  adcc_pkg::adcc_conv_req_t next_req;
  logic next_irq;

  // Bus decode; a request is taken once, in the cycle before ack
  logic bus_req, wr_lane, sc1_wr, sc2_wr, cmp_lo_wr, cmp_hi_wr, res_lo_rd, hw_edge;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane = bus_req && wb_we_i && wb_sel_i[0];
  assign sc1_wr = wr_lane && reg_hit(wb_adr_i, adcc_pkg::SC1_OFS);
  assign sc2_wr = wr_lane && reg_hit(wb_adr_i, adcc_pkg::SC2_OFS);
  assign cmp_lo_wr = wr_lane && reg_hit(wb_adr_i, adcc_pkg::CMP_LO_OFS);
  assign cmp_hi_wr = wr_lane && reg_hit(wb_adr_i, adcc_pkg::CMP_HI_OFS);
  assign res_lo_rd = bus_req && !wb_we_i && reg_hit(wb_adr_i, adcc_pkg::RES_LO_OFS);
  // Edge taken only after the two-flop synchroniser
  assign hw_edge = trig_s2 && !trig_prev;

  // ==========================================================
  // Next-state computation
  always_comb begin
    next_state = state;
    next_done_flag = done_flag;
    next_irq_en = irq_en;
    next_cont_en = cont_en;
    next_channel_select = channel_select;
    next_trig_hw = trig_hw;
    next_cmp_en = cmp_en;
    next_cmp_gt = cmp_gt;
    next_cmp_value = cmp_value;
    next_result = result;
    next_req = '0;

    // Second control register and compare value
    if (sc2_wr) begin
      next_trig_hw = wb_dat_i[adcc_pkg::TRIG_BIT];
      next_cmp_en = wb_dat_i[adcc_pkg::CMP_EN_BIT];
      next_cmp_gt = wb_dat_i[adcc_pkg::CMP_GT_BIT];
    end
    if (cmp_lo_wr) begin
      next_cmp_value[7:0] = wb_dat_i[7:0];
    end
    if (cmp_hi_wr) begin
      next_cmp_value[9:8] = wb_dat_i[1:0];
    end

    // Low-result read clears the flag; a completion below that passes the compare sets it again
    if (res_lo_rd) begin
      next_done_flag = 1'b0;
    end

    if (sc1_wr) begin
      // Abort wins over a completion in this cycle, so result stays put
      next_req.abort = (state == adcc_pkg::ADCC_CONVERT);
      next_done_flag = 1'b0;
      next_irq_en = wb_dat_i[adcc_pkg::IRQ_EN_BIT];
      next_cont_en = wb_dat_i[adcc_pkg::CONT_BIT];
      next_channel_select = wb_dat_i[4:0];
      if (wb_dat_i[4:0] != adcc_pkg::CH_OFF && !next_trig_hw) begin
        next_req.start = 1'b1;
        next_state = adcc_pkg::ADCC_CONVERT;
      end else begin
        next_state = adcc_pkg::ADCC_IDLE;
      end
    end else if (state == adcc_pkg::ADCC_IDLE) begin
      // Hardware start event; ignored while the module is off
      if (trig_hw && hw_edge && channel_select != adcc_pkg::CH_OFF) begin
        next_req.start = 1'b1;
        next_state = adcc_pkg::ADCC_CONVERT;
      end
    end else if (conv_ans.done) begin
      if (cmp_pass(cmp_en, cmp_gt, conv_ans.result, cmp_value)) begin
        next_done_flag = 1'b1;
        next_result = conv_ans.result;
      end
      if (cont_en) begin
        next_req.start = 1'b1;
      end else begin
        next_state = adcc_pkg::ADCC_IDLE;
      end
    end

    // Analog routing follows the channel code
    next_req.input_index = (next_channel_select <= adcc_pkg::CH_LAST_INPUT) ? next_channel_select : 5'h00;
    next_req.ref_high = (next_channel_select == adcc_pkg::CH_REF_HIGH);
    next_req.ref_low = (next_channel_select == adcc_pkg::CH_REF_LOW);
    // Reserved code and off code both isolate; only off is a documented disable
    next_req.isolate = (next_channel_select >= adcc_pkg::CH_RESERVED) && !next_req.ref_high && !next_req.ref_low;
    next_req.low_power = (next_state == adcc_pkg::ADCC_IDLE);
    next_irq = next_done_flag && next_irq_en;
  end

  // Bus answer: one wait state, data registered with ack
  always_comb begin
    next_ack = bus_req;
    next_dat = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      if (reg_hit(wb_adr_i, adcc_pkg::SC1_OFS)) begin
        next_dat[7:0] = {done_flag, irq_en, cont_en, channel_select};
      end else if (reg_hit(wb_adr_i, adcc_pkg::SC2_OFS)) begin
        next_dat[7:0] = {state == adcc_pkg::ADCC_CONVERT, trig_hw, cmp_en, cmp_gt, 4'h0};
      end else if (reg_hit(wb_adr_i, adcc_pkg::RES_LO_OFS)) begin
        next_dat[7:0] = result[7:0];
      end else if (reg_hit(wb_adr_i, adcc_pkg::RES_HI_OFS)) begin
        next_dat[1:0] = result[9:8];
      end else if (reg_hit(wb_adr_i, adcc_pkg::CMP_LO_OFS)) begin
        next_dat[7:0] = cmp_value[7:0];
      end else if (reg_hit(wb_adr_i, adcc_pkg::CMP_HI_OFS)) begin
        next_dat[1:0] = cmp_value[9:8];
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= adcc_pkg::ADCC_IDLE;
      done_flag <= adcc_pkg::SC1_RESET[adcc_pkg::DONE_BIT];
      irq_en <= adcc_pkg::SC1_RESET[adcc_pkg::IRQ_EN_BIT];
      cont_en <= adcc_pkg::SC1_RESET[adcc_pkg::CONT_BIT];
      channel_select <= adcc_pkg::SC1_RESET[4:0];
      trig_hw <= adcc_pkg::SC2_RESET[adcc_pkg::TRIG_BIT];
      cmp_en <= adcc_pkg::SC2_RESET[adcc_pkg::CMP_EN_BIT];
      cmp_gt <= adcc_pkg::SC2_RESET[adcc_pkg::CMP_GT_BIT];
      cmp_value <= adcc_pkg::CMP_RESET;
      result <= 10'h000;
      conv_req <= '{start: 1'b0, abort: 1'b0, input_index: 5'h00, ref_high: 1'b0, ref_low: 1'b0,
                    isolate: 1'b1, low_power: 1'b1};
      irq <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      state <= next_state;
      done_flag <= next_done_flag;
      irq_en <= next_irq_en;
      cont_en <= next_cont_en;
      channel_select <= next_channel_select;
      trig_hw <= next_trig_hw;
      cmp_en <= next_cmp_en;
      cmp_gt <= next_cmp_gt;
      cmp_value <= next_cmp_value;
      result <= next_result;
      conv_req <= next_req;
      irq <= next_irq;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      trig_s1 <= hw_trigger_in;
      trig_s2 <= trig_s1;
      trig_prev <= trig_s2;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  logic running;
  assign running = (state == adcc_pkg::ADCC_CONVERT);

  sequence s_off_write;
    sc1_wr && wb_dat_i[4:0] == adcc_pkg::CH_OFF;
  endsequence

  sequence s_quiet_off;
    conv_req.isolate && conv_req.low_power && !conv_req.start && !running;
  endsequence

  sequence s_single_done;
    running && conv_ans.done && !cont_en && !sc1_wr;
  endsequence

  a_write_aborts_run: assert property (sc1_wr && running |=> conv_req.abort)
    else $error("control write did not abort running conversion");
  a_write_starts_sw: assert property (sc1_wr && wb_dat_i[4:0] != adcc_pkg::CH_OFF && !trig_hw && !sc2_wr
                                      |=> conv_req.start && running)
    else $error("software write did not start conversion");
  a_done_no_cmp: assert property (running && conv_ans.done && !cmp_en && !sc1_wr |=> done_flag)
    else $error("completion without compare did not set flag");
  a_done_cmp_miss: assert property (running && conv_ans.done && cmp_en && !sc1_wr && !done_flag
                                    && !cmp_pass(1'b1, cmp_gt, conv_ans.result, cmp_value)
                                    |=> !done_flag && result == $past(result))
    else $error("compare miss changed flag or result");
  a_write_clears_flag: assert property (sc1_wr |=> !done_flag)
    else $error("control write left flag set");
  a_irq_follows_flag: assert property (done_flag && irq_en |-> irq)
    else $error("interrupt missing while flag and enable set");
  a_irq_drops: assert property (irq |-> done_flag && irq_en)
    else $error("interrupt without flag and enable");
  a_single_low_power: assert property (s_single_done |=> !running && conv_req.low_power && !conv_req.start)
    else $error("single conversion did not return to low power");
  a_off_code_quiet: assert property (s_off_write |=> s_quiet_off ##1 !conv_req.start)
    else $error("off code did not stop and isolate");
  a_start_sets_run: assert property (conv_req.start |-> running)
    else $error("start without running status");
  a_cont_restarts: assert property (running && conv_ans.done && cont_en && !sc1_wr |=> conv_req.start && running)
    else $error("continuous mode did not restart");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  // ==========================================================
  // Routing, power and abort checks
  // Routing is registered from the same next value as the code, so they never disagree
  a_route_inputs: assert property (channel_select <= adcc_pkg::CH_LAST_INPUT
                                   |-> conv_req.input_index == channel_select && !conv_req.isolate)
    else $error("input code not routed to its input");
  a_route_refs: assert property (conv_req.ref_high == (channel_select == adcc_pkg::CH_REF_HIGH)
                                 && conv_req.ref_low == (channel_select == adcc_pkg::CH_REF_LOW))
    else $error("reference selection does not match code");
  a_off_isolates: assert property (channel_select == adcc_pkg::CH_OFF
                                   |-> conv_req.isolate && conv_req.low_power)
    else $error("off code left input connected or core powered");
  a_power_tracks_run: assert property (conv_req.low_power == !running)
    else $error("low power does not follow idle state");
  // A software-mode idle block must never start on its own, whatever the trigger pin does
  a_sw_no_start: assert property (!trig_hw && !sc1_wr && !running |=> !conv_req.start)
    else $error("start without a control write in software mode");
  a_read_clears_flag: assert property (res_lo_rd && !(running && conv_ans.done) |=> !done_flag)
    else $error("low result read left flag set");
  // A write that aborts must not let the dying conversion reach the result
  a_abort_keeps_result: assert property (sc1_wr && running |=> result == $past(result))
    else $error("aborted conversion changed the result");
  // Stopping a run with the off code aborts it and must not sneak in one more conversion
  a_off_stops_run: assert property (sc1_wr && wb_dat_i[4:0] == adcc_pkg::CH_OFF && running
                                    |=> conv_req.abort && !conv_req.start)
    else $error("off code during a run did not abort cleanly");
endmodule

/* adcc_core_model.sv */
// Behavioural model of the analog converter core behind the control block.
// Assumes one-cycle start and abort pulses on ref_clk; latency comes from delay.
`timescale 1ns/1ps
module adcc_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire adcc_pkg::adcc_conv_req_t conv_req,
  input wire logic [9:0] sample,
  input wire logic [7:0] delay,
  output adcc_pkg::adcc_conv_ans_t conv_ans
);
  // =====
  // Conversion timer
  logic busy;
  logic [7:0] left;
  // Result lines toggle outside done, so a stale value never passes as fresh
  always @(posedge ref_clk) begin
    conv_ans.done <= 1'b0;
    conv_ans.result <= ~conv_ans.result;
    if (!nrst) begin
      busy <= 1'b0;
      conv_ans.result <= 10'h000;
    end else if (conv_req.start) begin
      busy <= 1'b1;
      left <= delay;
    end else if (conv_req.abort) begin
      busy <= 1'b0;
    end else if (busy && left == 8'h00) begin
      busy <= 1'b0;
      conv_ans.done <= 1'b1;
      conv_ans.result <= sample;
    end else begin
      left <= left - 8'h01;
    end
  end
endmodule

/* adcc_ctrl_tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the package and core model are compiled first; 50 ns clock.
`timescale 1ns/1ps
module adcc_ctrl_tb_top;
  // =====
  // Signals and instances
  localparam logic [7:0] A1 = adcc_pkg::SC1_OFS;
  localparam logic [7:0] A2 = adcc_pkg::SC2_OFS;
  localparam logic [7:0] RL = adcc_pkg::RES_LO_OFS;
  logic ref_clk = 1'b0, nrst = 1'b0, bus_on = 1'b0, we = 1'b0, hw = 1'b0, ack, irq, go;
  logic [7:0] adr = 8'h00, dly = 8'h00, rd;
  logic [31:0] wdat = 32'h0, dat_o;
  logic [9:0] smp = 10'h000;
  adcc_pkg::adcc_conv_req_t req;
  adcc_pkg::adcc_conv_ans_t ans;
  int failures = 0, checks_done = 0, starts = 0, dones = 0, aborts = 0, n0, a0;
  // Channel code beside expected {index, ref high, ref low, isolate}
  logic [7:0] rows [6][2] = '{'{8'h00, 8'h00}, '{8'h1b, 8'hd8}, '{8'h1c, 8'h01}, '{8'h1d, 8'h04},
    '{8'h1e, 8'h02}, '{8'h1f, 8'h01}};
  adcc_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(bus_on), .wb_stb_i(bus_on), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .hw_trigger_in(hw), .conv_ans(ans), .conv_req(req), .irq(irq));
  adcc_core_model core_u (.ref_clk(ref_clk), .nrst(nrst), .conv_req(req), .sample(smp), .delay(dly),
    .conv_ans(ans));
  always #25 ref_clk = ~ref_clk;
  // Pulse counters; the bus tasks never see these edges directly
  always @(posedge ref_clk) begin
    starts <= starts + (req.start === 1'b1);
    dones <= dones + (ans.done === 1'b1);
    aborts <= aborts + (req.abort === 1'b1);
  end
  // =====
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    bus_on <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o[7:0];
    bus_on <= 1'b0;
    if (n == 50) failures++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_cycle(1'b1, a, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    wb_cycle(1'b0, a, 8'h00, rd);
    check(rd, exp);
  endtask
  // Waits for a fresh completion, or just watches a quiet window
  task automatic wait_end(input logic g);
    int n, d0;
    n = 0;
    d0 = dones;
    while (g && dones == d0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 300) failures++;
    repeat (g ? 3 : 20) @(posedge ref_clk);
  endtask
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // =====
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    check(req.low_power, 1'b1);
    rd_chk(A1, 8'h1f);
    rd_chk(A2, 8'h00);
    rd_chk(8'h40, 8'h00);
    foreach (rows[i]) begin
      go = rows[i][0] != 8'h1f;
      n0 = starts;
      smp <= {rows[i][0][4:0], rows[i][0][4:0]};
      wr(A1, rows[i][0]);
      wait_end(go);
      check({req.input_index, req.ref_high, req.ref_low, req.isolate}, rows[i][1]);
      check(16'(starts - n0), go);
      check(req.low_power, 1'b1);
      rd_chk(A1, {go, 2'b00, rows[i][0][4:0]});
      if (go) rd_chk(RL, {rows[i][0][2:0], rows[i][0][4:0]});
    end
    // Slow partner, abort in mid-run, then interrupt
    dly <= 8'h08;
    smp <= 10'h3cc;
    n0 = starts;
    a0 = aborts;
    wr(A1, 8'h43);
    rd_chk(A2, 8'h80);
    wr(A1, 8'h44);
    wait_end(1'b1);
    check(16'(starts - n0), 16'h2);
    check(16'(aborts - a0), 16'h1);
    rd_chk(A2, 8'h00);
    check(irq, 1'b1);
    rd_chk(A1, 8'hc4);
    wr(A1, 8'hdf);
    rd_chk(A1, 8'h5f);
    check(irq, 1'b0);
    // Continuous run, stopped by the off code
    n0 = starts;
    wr(A1, 8'h21);
    repeat (3) wait_end(1'b1);
    check(16'(starts - n0), 16'h4);
    n0 = starts;
    a0 = aborts;
    smp <= 10'h111;
    wr(A1, 8'h3f);
    wait_end(1'b0);
    check(16'(starts - n0), 16'h0);
    check(16'(aborts - a0), 16'h1);
    rd_chk(RL, 8'hcc);
    check(req.low_power, 1'b1);
    // Compare: less-than misses, greater-or-equal hits
    wr(adcc_pkg::CMP_LO_OFS, 8'h10);
    smp <= 10'h050;
    for (int k = 0; k < 2; k++) begin
      wr(A2, k ? 8'h30 : 8'h20);
      wr(A1, 8'h02);
      wait_end(1'b1);
      rd_chk(A1, {k[0], 7'h02});
      rd_chk(RL, k ? 8'h50 : 8'hcc);
    end
    rd_chk(A1, 8'h02);
    // Hardware trigger: write alone starts nothing, one edge one conversion
    wr(A2, 8'h40);
    n0 = starts;
    wr(A1, 8'h06);
    wait_end(1'b0);
    check(16'(starts - n0), 16'h0);
    hw <= 1'b1;
    wait_end(1'b1);
    hw <= 1'b0;
    wait_end(1'b0);
    check(16'(starts - n0), 16'h1);
    rd_chk(A1, 8'h86);
    // Reset in the middle of a slow conversion: everything back to off, nothing left running
    wr(A2, 8'h00);
    dly <= 8'h20;
    wr(A1, 8'h45);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    check(irq, 1'b0);
    check(req.low_power, 1'b1);
    n0 = starts;
    rd_chk(A1, 8'h1f);
    rd_chk(A2, 8'h00);
    wait_end(1'b0);
    check(16'(starts - n0), 16'h0);
    summarize();
  end
  // Watchdog far beyond the expected run
  initial begin
    #1500000;
    failures++;
    summarize();
  end
endmodule
